// *** common/rsp_pkg.sv ***
/*
  package for the pipeline and scoreboard control block: widths, stage
  timing, operand classes and the carrier structs between decode and control.
  assumes one processor clock; nothing here is clocked.
*/
package rsp_pkg;

  localparam int INSTR_W = 16;
  localparam int DATA_W = 32;
  localparam int NUM_REGS = 64;
  localparam int BANK_REGS = 32;
  localparam int REG_IDX_W = 6;
  localparam int BANK_IDX_W = 5;
  localparam int DIV_TICKS = 18;
  localparam int DIV_CNT_W = 5;
  localparam logic [4:0] DIV_CNT_INIT = 5'(DIV_TICKS);
  localparam int NUM_WB_SRC = 4;
  localparam int WB_ALU = 0;
  localparam int WB_DIV = 1;
  localparam int WB_ILD = 2;
  localparam int WB_XLD = 3;
  localparam int CLK_PERIOD_NS = 50;

  // addressing modes of loads and stores
  typedef enum logic [1:0] {
    RSP_AM_IND,
    RSP_AM_IND_REG,
    RSP_AM_IND_IMM,
    RSP_AM_NONE
  } rsp_amode_t;

  // jump kinds
  typedef enum logic [1:0] {
    RSP_JMP_NONE,
    RSP_JMP_REL,
    RSP_JMP_ABS
  } rsp_jkind_t;

  // condition: mask and required value for zero, carry, negative
  typedef struct packed {
    logic [2:0] mask;
    logic [2:0] want;
  } rsp_cond_t;

  localparam int FLG_Z = 0;
  localparam int FLG_C = 1;
  localparam int FLG_N = 2;

  // decoded instruction presented by the decoder at stage 1
  typedef struct packed {
    logic valid;
    logic [REG_IDX_W-1:0] src_a;
    logic rd_a;
    logic [REG_IDX_W-1:0] src_b;
    logic rd_b;
    logic [REG_IDX_W-1:0] dst;
    logic wr_dst;
    logic dst_wonly;
    logic uses_flags;
    logic sets_flags;
    logic is_div;
    logic is_ild;
    logic is_xld;
    logic idx_store;
    rsp_amode_t amode;
    rsp_jkind_t jkind;
    rsp_cond_t cond;
  } rsp_dec_t;

  // write-back request of one source
  typedef struct packed {
    logic valid;
    logic [REG_IDX_W-1:0] idx;
  } rsp_wb_t;

endpackage : rsp_pkg

// *** verilog/rsp_div_timer.sv ***
/*
  divide latency timer: counts the fixed ticks from divide start to result
  and remembers the destination register. assumes CLK and a synchronous
  active-high reset; a new start while busy is held off by the caller.
*/
`timescale 1ns/1ps
`default_nettype none

module rsp_div_timer #(
  parameter int TICKS = rsp_pkg::DIV_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [rsp_pkg::REG_IDX_W-1:0] dst,
  output logic busy,
  output logic done,
  output logic [rsp_pkg::REG_IDX_W-1:0] dst_ff
);

  logic [rsp_pkg::DIV_CNT_W-1:0] cnt_ff;

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (start && !busy) begin
      cnt_ff <= rsp_pkg::DIV_CNT_W'(TICKS);
    end else if (busy) begin
      cnt_ff <= cnt_ff - 5'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dst_ff <= '0;
    end else if (start && !busy) begin
      dst_ff <= dst;
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = (cnt_ff == 5'h1); // result ready after TICKS ticks

endmodule : rsp_div_timer
`default_nettype wire

// *** verilog/rsp_pipe_ctrl.sv ***
/*
  pipeline and scoreboard control for a small 32-bit risc core: four-stage
  advance, register and flag scoreboard, write-back arbitration on a
  dual-port register file, delayed jumps and divide latency.
  assumes a decoder that presents one decoded 16-bit instruction at stage 1,
  and load units that report completion of internal and external loads.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - instructions are 16 bits; data paths 32 bits except multiply
// - sixty-four 32-bit registers, one bank of thirty-two visible
// - decode, read, compute, write-back; one tick per stage
// - scoreboard tags pending registers and stalls their readers
// - wait states when reading a result still in the alu
// - conditional jumps and carry arithmetic wait for pending flags
// - stall readers of registers loading from local memory
// - stall readers of an unfinished divide destination
// - divide runs in parallel and takes 18 ticks
// - stall readers of registers awaiting external memory
// - indexed store data register is never checked
// - write-back hidden if stage-1 reads it or has a free port
// - two simultaneous write-backs hold execution one tick
// - write-only destinations are not protected by the scoreboard
// - write-only destination may overtake an earlier write
// - jumps delayed until the following instruction executes
// - jump conditions combine zero, carry and negative flags
// - loads and stores: indirect, plus register, plus immediate
module rsp_pipe_ctrl #(
  parameter int DIV_TICKS = rsp_pkg::DIV_TICKS
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [rsp_pkg::INSTR_W-1:0] INSTR,
  input wire rsp_pkg::rsp_dec_t DEC,
  input wire logic BANK_SEL,
  input wire logic [2:0] ALU_FLAGS,
  input wire logic ILD_DONE,
  input wire logic [rsp_pkg::REG_IDX_W-1:0] ILD_IDX,
  input wire logic XLD_DONE,
  input wire logic [rsp_pkg::REG_IDX_W-1:0] XLD_IDX,
  input wire logic [rsp_pkg::DATA_W-1:0] JUMP_TARGET,
  output logic STALL,
  output logic ADVANCE,
  output logic [rsp_pkg::INSTR_W-1:0] INSTR_S2,
  output logic [rsp_pkg::NUM_WB_SRC-1:0] WB_GRANT,
  output logic [rsp_pkg::REG_IDX_W-1:0] WB_IDX,
  output logic [2:0] FLAGS,
  output logic JUMP_TAKE,
  output logic [rsp_pkg::DATA_W-1:0] JUMP_PC,
  output logic [1:0] AMODE,
  output logic [rsp_pkg::NUM_REGS-1:0] PEND_REGS
);

  // ----------------------------------------------------------------
  // pipeline registers
  // ----------------------------------------------------------------
  rsp_pkg::rsp_dec_t s2_ff;
  rsp_pkg::rsp_dec_t s3_ff;
  logic [rsp_pkg::NUM_REGS-1:0] tag_ff;
  logic flag_pend_ff;
  logic jump_armed_ff;
  logic [rsp_pkg::DATA_W-1:0] jump_tgt_ff;
  logic [rsp_pkg::NUM_WB_SRC-1:0] wb_req;
  logic [rsp_pkg::REG_IDX_W-1:0] wb_idx [rsp_pkg::NUM_WB_SRC];
  logic [rsp_pkg::NUM_WB_SRC-1:0] nxt_grant;
  logic [rsp_pkg::REG_IDX_W-1:0] nxt_wb_idx;
  logic [rsp_pkg::NUM_REGS-1:0] clr_mask;
  logic [rsp_pkg::NUM_REGS-1:0] set_mask;
  logic [rsp_pkg::REG_IDX_W-1:0] a_idx;
  logic [rsp_pkg::REG_IDX_W-1:0] b_idx;
  logic [rsp_pkg::REG_IDX_W-1:0] d_idx;
  logic haz_a;
  logic haz_b;
  logic haz_flag;
  logic haz_div;
  logic haz_port;
  logic haz_multi;
  logic hold;
  logic go;
  logic cond_ok;
  logic div_busy;
  logic div_done;
  logic [rsp_pkg::REG_IDX_W-1:0] div_dst;
  logic div_wait_ff;

  // bank select forms the physical register index of the visible half
  function automatic logic [rsp_pkg::REG_IDX_W-1:0] phys(
    input logic [rsp_pkg::REG_IDX_W-1:0] idx,
    input logic bank
  );
    phys = {bank, idx[rsp_pkg::BANK_IDX_W-1:0]};
  endfunction : phys

  assign a_idx = phys(DEC.src_a, BANK_SEL);
  assign b_idx = phys(DEC.src_b, BANK_SEL);
  assign d_idx = phys(DEC.dst, BANK_SEL);

  // ----------------------------------------------------------------
  // divide latency
  // ----------------------------------------------------------------
  rsp_div_timer #(
    .TICKS(DIV_TICKS)
  ) u_div (
    .clk(CLK),
    .rst(RST),
    .start(go && DEC.valid && DEC.is_div),
    .dst(d_idx),
    .busy(div_busy),
    .done(div_done),
    .dst_ff(div_dst)
  );

  // done is a single pulse; a divide result that loses arbitration would be
  // lost and its tag never cleared, so keep asking until granted
  always_ff @(posedge CLK) begin
    if (RST) begin
      div_wait_ff <= 1'b0;
    end else if (nxt_grant[rsp_pkg::WB_DIV]) begin
      div_wait_ff <= 1'b0;
    end else if (div_done) begin
      div_wait_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // write-back sources
  // ----------------------------------------------------------------
  always_comb begin
    wb_req = '0;
    wb_req[rsp_pkg::WB_ALU] = s3_ff.valid && s3_ff.wr_dst && !s3_ff.is_div &&
                              !s3_ff.is_ild && !s3_ff.is_xld;
    wb_req[rsp_pkg::WB_DIV] = div_done || div_wait_ff;
    wb_req[rsp_pkg::WB_ILD] = ILD_DONE;
    wb_req[rsp_pkg::WB_XLD] = XLD_DONE;
    wb_idx[rsp_pkg::WB_ALU] = s3_ff.dst;
    wb_idx[rsp_pkg::WB_DIV] = div_dst;
    wb_idx[rsp_pkg::WB_ILD] = ILD_IDX;
    wb_idx[rsp_pkg::WB_XLD] = XLD_IDX;
  end

  // fixed priority; the loser retries next tick with execution held
  always_comb begin
    nxt_grant = '0;
    nxt_wb_idx = '0;
    for (int i = rsp_pkg::NUM_WB_SRC - 1; i >= 0; i--) begin
      if (wb_req[i]) begin
        nxt_grant = '0;
        nxt_grant[i] = 1'b1;
        nxt_wb_idx = wb_idx[i];
      end
    end
  end

  // more than one source at once costs a tick
  assign haz_multi = (wb_req & (wb_req - 4'h1)) != '0;

  // a write-back needs a port unless stage 1 reads that register or has a
  // free port; two other reads clash with the write
  assign haz_port = (wb_req != '0) && DEC.valid && DEC.rd_a && DEC.rd_b &&
                    !(a_idx == nxt_wb_idx || b_idx == nxt_wb_idx);

  // ----------------------------------------------------------------
  // hazard detection
  // ----------------------------------------------------------------
  // tag clears in the write-back cycle and a waiting reader goes in that same tick
  assign haz_a = DEC.rd_a && tag_ff[a_idx] &&
                 !(wb_req != '0 && nxt_wb_idx == a_idx);
  // indexed store data skips the check; software reads it first
  assign haz_b = DEC.rd_b && !DEC.idx_store && tag_ff[b_idx] &&
                 !(wb_req != '0 && nxt_wb_idx == b_idx);
  assign haz_flag = DEC.uses_flags && flag_pend_ff;
  // a second divide waits for the unit to become free
  assign haz_div = DEC.is_div && (div_busy || div_wait_ff);

  assign hold = DEC.valid &&
                (haz_a || haz_b || haz_flag || haz_div || haz_port ||
                 haz_multi);
  assign go = !hold;

  // ----------------------------------------------------------------
  // scoreboard tags
  // ----------------------------------------------------------------
  always_comb begin
    clr_mask = '0;
    set_mask = '0;
    if (wb_req != '0) begin
      clr_mask[nxt_wb_idx] = 1'b1;
    end
    // write-only destinations are not tagged; they can overtake a pending
    // write to the same register, which software must avoid
    if (go && DEC.valid && DEC.wr_dst && !DEC.dst_wonly) begin
      set_mask[d_idx] = 1'b1;
    end
    // loads are write-only but still tag so readers wait on memory
    if (go && DEC.valid && (DEC.is_ild || DEC.is_xld || DEC.is_div)) begin
      set_mask[d_idx] = 1'b1;
    end
  end

  // a new tag set wins over a clear in the same tick
  always_ff @(posedge CLK) begin
    if (RST) begin
      tag_ff <= '0;
    end else begin
      tag_ff <= (tag_ff & ~clr_mask) | set_mask;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      flag_pend_ff <= 1'b0;
    end else if (go && DEC.valid && DEC.sets_flags) begin
      flag_pend_ff <= 1'b1;
    end else if (s3_ff.valid && s3_ff.sets_flags) begin
      flag_pend_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // stage advance
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      s2_ff <= '0;
    end else if (go) begin
      s2_ff <= DEC;
      s2_ff.dst <= d_idx;
    end else begin
      s2_ff.valid <= 1'b0; // bubble while stage 1 waits
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s3_ff <= '0;
    end else begin
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      INSTR_S2 <= '0;
    end else if (go) begin
      INSTR_S2 <= INSTR;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      AMODE <= 2'(rsp_pkg::RSP_AM_NONE);
    end else if (go && DEC.valid) begin
      AMODE <= 2'(DEC.amode);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      STALL <= 1'b0;
      ADVANCE <= 1'b0;
    end else begin
      STALL <= hold;
      ADVANCE <= go && DEC.valid;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      WB_GRANT <= '0;
      WB_IDX <= '0;
      PEND_REGS <= '0;
    end else begin
      WB_GRANT <= nxt_grant;
      WB_IDX <= nxt_wb_idx;
      PEND_REGS <= (tag_ff & ~clr_mask) | set_mask;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      FLAGS <= '0;
    end else if (s3_ff.valid && s3_ff.sets_flags) begin
      FLAGS <= ALU_FLAGS;
    end
  end

  // ----------------------------------------------------------------
  // delayed jumps
  // ----------------------------------------------------------------
  // condition over zero, carry and negative with a mask
  assign cond_ok = ((FLAGS ^ DEC.cond.want) & DEC.cond.mask) == 3'h0;

  // jumps in internal ram only; fetch source is not checked
  always_ff @(posedge CLK) begin
    if (RST) begin
      jump_armed_ff <= 1'b0;
      jump_tgt_ff <= '0;
    end else if (go && DEC.valid) begin
      jump_armed_ff <= (DEC.jkind != rsp_pkg::RSP_JMP_NONE) && cond_ok;
      jump_tgt_ff <= JUMP_TARGET;
    end
  end

  // transfer fires when the slot instruction advances
  always_ff @(posedge CLK) begin
    if (RST) begin
      JUMP_TAKE <= 1'b0;
      JUMP_PC <= '0;
    end else begin
      JUMP_TAKE <= jump_armed_ff && go && DEC.valid;
      JUMP_PC <= jump_tgt_ff;
    end
  end

endmodule : rsp_pipe_ctrl
`default_nettype wire

// *** testbench/rsp_pipe_ctrl_props.sv ***
/* checker on the pipeline control ports, bound into the pipeline control module.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module rsp_pipe_ctrl_props #(
  parameter int DIV_TICKS = 18
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [15:0] INSTR,
  input wire rsp_pkg::rsp_dec_t DEC,
  input wire logic BANK_SEL,
  input wire logic ILD_DONE,
  input wire logic XLD_DONE,
  input wire logic [5:0] XLD_IDX,
  input wire logic STALL,
  input wire logic ADVANCE,
  input wire logic [15:0] INSTR_S2,
  input wire logic [3:0] WB_GRANT,
  input wire logic [5:0] WB_IDX,
  input wire logic JUMP_TAKE,
  input wire logic [1:0] AMODE,
  input wire logic [63:0] PEND_REGS
);
  // ----------
  // properties
  // ----------
  // loose divide window: a busy write-back port may push it out
  localparam int DLO = DIV_TICKS - 3;
  localparam int DHI = DIV_TICKS + 8;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence div_go;
    DEC.valid && DEC.is_div ##1 ADVANCE;
  endsequence
  sequence flg_go;
    DEC.valid && DEC.sets_flags ##1 ADVANCE;
  endsequence
  AST_ONE_STATE:
  assert property (!(ADVANCE && STALL))
    else $error("advance and stall together");
  AST_INSTR_S2:
  assert property (ADVANCE |-> INSTR_S2 == $past(INSTR))
    else $error("stage two word wrong");
  AST_TAG_STALL:
  assert property (DEC.valid && DEC.rd_a &&
    PEND_REGS[{BANK_SEL, DEC.src_a[4:0]}] |=> !ADVANCE ||
    (WB_GRANT != 4'h0 && WB_IDX == $past({BANK_SEL, DEC.src_a[4:0]})))
    else $error("tagged read not held");
  AST_FLAG_STALL:
  assert property (flg_go ##0 (DEC.valid && DEC.uses_flags) |=> !ADVANCE)
    else $error("flag user not held");
  AST_DIV_QUIET:
  assert property (div_go |-> !WB_GRANT[1] [*8])
    else $error("divide result too early");
  AST_DIV_DONE:
  assert property (div_go |-> ##[DLO:DHI] WB_GRANT[1])
    else $error("divide result missing");
  AST_WB_ONEHOT:
  assert property ($onehot0(WB_GRANT))
    else $error("two write-backs granted");
  AST_DUAL:
  assert property (DEC.valid && ILD_DONE && XLD_DONE |=> !ADVANCE)
    else $error("dual write-back not held");
  AST_XLD_IDX:
  assert property (WB_GRANT[3] |-> $past(XLD_DONE) && WB_IDX == $past(XLD_IDX))
    else $error("external load index wrong");
  AST_JUMP_SLOT:
  assert property (JUMP_TAKE |-> ADVANCE)
    else $error("jump taken without slot advance");
  AST_AMODE:
  assert property (ADVANCE |-> AMODE == $past(DEC.amode))
    else $error("address mode wrong");
endmodule : rsp_pipe_ctrl_props
bind rsp_pipe_ctrl rsp_pipe_ctrl_props #(.DIV_TICKS(DIV_TICKS)) props_u (
  .CLK(CLK), .RST(RST), .INSTR(INSTR), .DEC(DEC), .BANK_SEL(BANK_SEL),
  .ILD_DONE(ILD_DONE), .XLD_DONE(XLD_DONE), .XLD_IDX(XLD_IDX),
  .STALL(STALL), .ADVANCE(ADVANCE), .INSTR_S2(INSTR_S2),
  .WB_GRANT(WB_GRANT), .WB_IDX(WB_IDX), .JUMP_TAKE(JUMP_TAKE),
  .AMODE(AMODE), .PEND_REGS(PEND_REGS)
);
`default_nettype wire

// *** testbench/rsp_mem_model.sv ***
/* load memory model: answers local and external loads after a latency
   and holds each request until its write-back grant is seen.
   assumes grant bits 2 and 3 belong to local and external loads. */
`timescale 1ns/1ps
`default_nettype none
module rsp_mem_model (
  input wire logic clk,
  input wire logic [3:0] grant,
  output logic ild_done,
  output logic [5:0] ild_idx,
  output logic xld_done,
  output logic [5:0] xld_idx
);
  // ----------
  // load slots
  // ----------
  logic [1:0] busy, done;
  int cnt [2];
  logic [5:0] hold [2];
  initial begin
    busy = 2'h0;
    done = 2'h0;
    hold[0] = 6'h00;
    hold[1] = 6'h00;
  end
  task fetch(input int k, input logic [5:0] idx, input int lat);
    busy[k] <= 1'b1;
    cnt[k] <= lat;
    hold[k] <= idx;
  endtask : fetch
  always @(negedge clk) begin
    for (int k = 0; k < 2; k++) begin
      if (done[k] && grant[2 + k]) begin
        done[k] <= 1'b0;
        busy[k] <= 1'b0;
      end else if (busy[k] && cnt[k] == 0) begin
        done[k] <= 1'b1;
      end else if (busy[k]) begin
        cnt[k] <= cnt[k] - 1;
      end
    end
  end
  // released index shows the inverse so a stale match cannot pass
  assign ild_done = done[0];
  assign ild_idx = done[0] ? hold[0] : ~hold[0];
  assign xld_done = done[1];
  assign xld_idx = done[1] ? hold[1] : ~hold[1];
endmodule : rsp_mem_model
`default_nettype wire

// *** testbench/rsp_pipe_ctrl_bench.sv ***
/* bench for the pipeline control block with the load model beside it.
   assumes package, design, model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module rsp_pipe_ctrl_bench;
  // -------
  // wiring
  // -------
  logic clk, rst, bank, ild_done, xld_done, stall, adv, jtake, e;
  logic [15:0] instr, instr_s2;
  logic [2:0] alu_flags, flags;
  logic [5:0] ild_idx, xld_idx, wb_idx;
  logic [31:0] jtgt, jpc;
  logic [3:0] grant;
  logic [1:0] amode;
  logic [63:0] pend;
  rsp_pkg::rsp_dec_t dec, d;
  int err_count, total_checks, seed, w, lat;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  rsp_pipe_ctrl dut_u (
    .CLK(clk), .RST(rst), .INSTR(instr), .DEC(dec), .BANK_SEL(bank),
    .ALU_FLAGS(alu_flags), .ILD_DONE(ild_done), .ILD_IDX(ild_idx),
    .XLD_DONE(xld_done), .XLD_IDX(xld_idx), .JUMP_TARGET(jtgt),
    .STALL(stall), .ADVANCE(adv), .INSTR_S2(instr_s2), .WB_GRANT(grant),
    .WB_IDX(wb_idx), .FLAGS(flags), .JUMP_TAKE(jtake), .JUMP_PC(jpc),
    .AMODE(amode), .PEND_REGS(pend)
  );
  rsp_mem_model mem_u (
    .clk(clk), .grant(grant), .ild_done(ild_done), .ild_idx(ild_idx),
    .xld_done(xld_done), .xld_idx(xld_idx)
  );
  // -------
  // helpers
  // -------
  task automatic chk(input string what, input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // u holds read a, read b and write destination
  function automatic rsp_pkg::rsp_dec_t op(input logic [5:0] a, b, t,
      input logic [2:0] u);
    return {1'b1, a, u[2], b, u[1], t, u[0], 7'h00, 2'h3, 2'h0, 6'h00};
  endfunction : op
  function automatic logic ok(input logic [2:0] f, rsp_pkg::rsp_cond_t c);
    return ((f ^ c.want) & c.mask) == 3'h0;
  endfunction : ok
  // decoder holds the word steady until it advances
  task automatic issue(input rsp_pkg::rsp_dec_t x, output int n);
    dec = x;
    instr = 16'($random(seed));
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (adv !== 1'b1) chk("stall", stall, 1'b1);
    end while (adv !== 1'b1 && n < 80);
    chk("advance", adv, 1'b1);
    chk("stage2", instr_s2, instr);
    chk("amode", amode, x.amode);
    n--;
  endtask : issue
  task automatic idle(input int n);
    dec.valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle
  initial begin
    #500000;
    err_count++;
    tally_and_finish();
  end
  // --------
  // sequence
  // --------
  initial begin
    seed = 32'h33F72429;
    rst = 1'b1;
    dec = '0;
    instr = 16'h0000;
    bank = 1'b0;
    alu_flags = 3'h0;
    jtgt = 32'h00000000;
    err_count = 0;
    total_checks = 0;
    repeat (8) @(negedge clk);
    chk("reset tags", pend, 64'h0);
    chk("reset amode", amode, 2'h3);
    rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      bank = 1'($random(seed));
      alu_flags = 3'($random(seed));
      d = op(1, 2, 3, 3'h7);
      d.sets_flags = 1'b1;
      issue(d, w);
      d = op(4, 0, 0, 3'h4);
      d.uses_flags = 1'b1;
      d.jkind = rsp_pkg::rsp_jkind_t'(1 + i % 2); // local ram only
      d.cond = 6'($random(seed));
      e = ok(alu_flags, d.cond);
      jtgt = 32'($random(seed));
      issue(d, w);
      chk("flag wait", w > 0, 1'b1);
      chk("flags", flags, alu_flags);
      chk("jump early", jtake, 1'b0);
      d = op(7, 8, 9, 3'h7);
      d.amode = rsp_pkg::rsp_amode_t'(i % 3);
      issue(d, w);
      chk("jump", jtake, e);
      if (e) chk("jump pc", jpc, jtgt);
      issue(op(10, 11, 12, 3'h7), w);
      issue(op(12, 13, 14, 3'h7), w);
      chk("alu wait", w > 0, 1'b1);
    end
    d = op(1, 2, 20, 3'h7);
    d.is_div = 1'b1;
    issue(d, w);
    chk("div tag", pend[{bank, 5'd20}], 1'b1);
    issue(op(3, 4, 5, 3'h7), w);
    chk("parallel", w < 2, 1'b1);
    issue(op(20, 21, 22, 3'h7), w);
    chk("div wait", w > 8, 1'b1);
    chk("div clear", pend[{bank, 5'd20}], 1'b0);
    d = op(1, 2, 23, 3'h7);
    d.is_div = 1'b1;
    issue(d, w);
    d = op(14, 23, 0, 3'h6);
    d.idx_store = 1'b1;
    d.amode = rsp_pkg::RSP_AM_IND_REG;
    issue(d, w);
    chk("store", w < 2, 1'b1);
    issue(op(23, 14, 15, 3'h7), w);
    chk("store read", w > 8, 1'b1);
    idle(30);
    for (int k = 0; k < 2; k++) begin
      lat = 2 + ($random(seed) & 15);
      d = op(1, 0, 6'(25 + k), 3'h5);
      d.dst_wonly = 1'b1;
      d.is_ild = (k == 0);
      d.is_xld = (k == 1);
      issue(d, w);
      mem_u.fetch(k, {bank, 5'(25 + k)}, lat);
      issue(op(6'(25 + k), 1, 2, 3'h7), w);
      chk("load wait", w >= lat, 1'b1);
    end
    d.is_xld = 1'b0;
    d.is_ild = 1'b1;
    issue(d, w);
    mem_u.fetch(0, {bank, 5'd26}, 4);
    d.is_ild = 1'b0;
    d.is_xld = 1'b1;
    d.dst = 6'd28;
    issue(d, w);
    mem_u.fetch(1, {bank, 5'd28}, 3);
    for (int j = 0; j < 8; j++) issue(op(3, 4, 6'(5 + j), 3'h7), w);
    idle(30);
    chk("tags clear", pend, 64'h0);
    tally_and_finish();
  end
endmodule : rsp_pipe_ctrl_bench
`default_nettype wire
